// >>> timer_params.svh
// Constants for the wait one-shot timer: register offsets, field positions,
// reset values and count source codes.
// Assumes APB byte addresses with one aligned 32-bit word per register.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_TIMER_CONTROL 8'h00
`define OFS_ONESHOT_CONTROL 8'h04
`define OFS_TIMER_IO_CONTROL 8'h08
`define OFS_MODE 8'h0C
`define OFS_PRESCALER 8'h10
`define OFS_SECONDARY 8'h14
`define OFS_PRIMARY 8'h18
`define OFS_PIN_CONFIG 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_COUNT_START 0
`define BIT_COUNT_STATUS 1
`define BIT_FORCED_STOP 2
`define BIT_OS_START 0
`define BIT_OS_STOP 1
`define BIT_OS_ACTIVE 2
`define BIT_LEVEL_SEL 0
`define BIT_TRIG_EDGE 1
`define BIT_TRIG_EN 2
`define BIT_WAIT_MODE 0
`define FLD_SRC_HI 5
`define FLD_SRC_LO 4
`define BIT_PIN_BOTH 0
`define BIT_PIN_IN_EN 1
`define BIT_PIN_FILT_LO 2
`define BIT_PIN_FILT_HI 3
`define BIT_PIN_POL 4
`define BIT_PIN_IRQ 5

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RST_BYTE 8'hFF
`define SRC_DIV1 2'h0
`define SRC_DIV2 2'h1
`define SRC_DIV8 2'h2
`define SRC_NEIGHBOUR 2'h3
`define DIV8_LAST 3'h7
`define FILT_NONE 2'h0

`endif

// >>> timer_pkg.sv
// Types shared by the wait one-shot timer modules.
// Assumes timer_params.svh supplies the numeric constants.
package timer_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_PULSE = 2'b10
    } os_state_t;

    typedef struct packed {
        logic pin_interrupt_polarity;
        logic [1:0] filter_sel;
        logic pin_input_enable;
        logic pin_both_edge_select;
    } pin_cfg_t;

    typedef struct packed {
        logic pin_trigger_enable;
        logic pin_trigger_edge_select;
    } trig_cfg_t;

endpackage

// >>> count_source_sel.sv
// Count source selector: produces a one-cycle tick at pclk, pclk/2, pclk/8
// or on each neighbouring timer underflow pulse.
// Assumes the underflow pulse is one pclk cycle wide and on the same clock.
`timescale 1ns/1ps
`include "timer_params.svh"

module count_source_sel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] src_sel,
    input wire logic neighbour_underflow,
    output logic tick
);
    logic [2:0] div;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 3'h0;
        end else begin
            div <= div + 3'h1;
        end
    end

    // ----------------------------------------
    // Tick generation
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else begin
            unique case (src_sel)
                `SRC_DIV1: tick <= 1'b1;
                `SRC_DIV2: tick <= div[0];
                `SRC_DIV8: tick <= (div == `DIV8_LAST);
                `SRC_NEIGHBOUR: tick <= neighbour_underflow;
            endcase
        end
    end
endmodule

// >>> pin_trigger.sv
// External trigger pin front end: synchroniser, digital filter and edge
// detection for the timer trigger and for the pin interrupt request.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
`include "timer_params.svh"

module pin_trigger (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic external_trigger_pin,
    input wire timer_pkg::pin_cfg_t cfg,
    input wire timer_pkg::trig_cfg_t tcfg,
    output logic trig,
    output logic irq_edge
);
    import timer_pkg::*;

    logic sync1;
    logic sync2;
    logic filt;
    logic [2:0] same_cnt;
    logic rise;
    logic fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= external_trigger_pin;
            sync2 <= sync1;
        end
    end

    // Filter accepts a new level after 2*sel+1 equal samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt <= 1'b1;
            same_cnt <= 3'h0;
        end else if (sync2 == filt || cfg.filter_sel == `FILT_NONE) begin
            filt <= sync2;
            same_cnt <= 3'h0;
        end else if (same_cnt >= {cfg.filter_sel, 1'b0}) begin
            filt <= sync2;
            same_cnt <= 3'h0;
        end else begin
            same_cnt <= same_cnt + 3'h1;
        end
    end

    always_comb begin
        rise = 1'b0;
        fall = 1'b0;
        if (cfg.filter_sel == `FILT_NONE) begin
            rise = sync2 & ~filt;
            fall = ~sync2 & filt;
        end else if (sync2 != filt && same_cnt >= {cfg.filter_sel, 1'b0}) begin
            rise = sync2;
            fall = ~sync2;
        end
    end

    // Timer edge and interrupt edge are chosen independently unless pin_both_edge_select makes both use either edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig <= 1'b0;
            irq_edge <= 1'b0;
        end else begin
            trig <= tcfg.pin_trigger_enable & (cfg.pin_both_edge_select ? (rise | fall) :
                    (tcfg.pin_trigger_edge_select ? rise : fall));
            irq_edge <= cfg.pin_input_enable & (cfg.pin_both_edge_select ? (rise | fall) :
                        (cfg.pin_interrupt_polarity ? rise : fall));
        end
    end
endmodule

// >>> wait_oneshot_timer.sv
// Wait one-shot timer with 8-bit prescaler and 8-bit counter, APB slave.
// Assumes one pclk domain; the trigger pin is asynchronous.
`timescale 1ns/1ps
`include "timer_params.svh"

module wait_oneshot_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_trigger_pin,
    input wire logic neighbour_underflow,
    output logic pulse_output_pin,
    output logic timer_request
);
    import timer_pkg::*;

    logic count_start_bit;
    logic count_status_flag;
    logic start_stage;
    logic oneshot_active_flag;
    logic os_start_pend;
    logic os_stop_pend;
    logic os_start_stage;
    logic os_stop_stage;
    logic output_level_select;
    logic wait_mode;
    logic [1:0] src_sel;
    trig_cfg_t tcfg;
    pin_cfg_t pcfg;
    logic interrupt_request_flag;
    logic [7:0] pre_rl;
    logic [7:0] sec_rl;
    logic [7:0] pri_rl;
    logic [7:0] pre_cnt;
    logic [7:0] cnt;
    os_state_t state;
    logic fin_q;
    logic tick;
    logic pin_trig;
    logic pin_irq;
    logic wr;
    logic setup;
    logic wr_ctrl;
    logic wr_os;
    logic wr_pre;
    logic wr_pri;
    logic force_stop;
    logic trig_accept;
    logic stop_now;
    logic fin;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `OFS_TIMER_CONTROL) || (a == `OFS_ONESHOT_CONTROL) ||
                 (a == `OFS_TIMER_IO_CONTROL) || (a == `OFS_MODE) || (a == `OFS_PRESCALER) ||
                 (a == `OFS_SECONDARY) || (a == `OFS_PRIMARY) || (a == `OFS_PIN_CONFIG);
    endfunction

    function automatic logic wr_at(input logic [7:0] a, input logic [7:0] ofs);
        wr_at = (a == ofs);
    endfunction

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    count_source_sel u_src (
        .pclk(pclk),
        .presetn(presetn),
        .src_sel(src_sel),
        .neighbour_underflow(neighbour_underflow),
        .tick(tick)
    );

    // Pin must be fully configured before its trigger is enabled; not checked here
    pin_trigger u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .external_trigger_pin(external_trigger_pin),
        .cfg(pcfg),
        .tcfg(tcfg),
        .trig(pin_trig),
        .irq_edge(pin_irq)
    );

    // ----------------------------------------
    // APB decode, zero wait states
    // ----------------------------------------
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready;
    assign wr_ctrl = wr & wr_at(paddr, `OFS_TIMER_CONTROL);
    assign wr_os = wr & wr_at(paddr, `OFS_ONESHOT_CONTROL);
    assign wr_pre = wr & wr_at(paddr, `OFS_PRESCALER);
    assign wr_pri = wr & wr_at(paddr, `OFS_PRIMARY);
    assign force_stop = wr_ctrl & pwdata[`BIT_FORCED_STOP];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= ~mapped(paddr);
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    `OFS_TIMER_CONTROL: begin
                        prdata[`BIT_COUNT_START] <= count_start_bit;
                        prdata[`BIT_COUNT_STATUS] <= count_status_flag;
                    end
                    `OFS_ONESHOT_CONTROL: prdata[`BIT_OS_ACTIVE] <= oneshot_active_flag;
                    `OFS_TIMER_IO_CONTROL: begin
                        prdata[`BIT_LEVEL_SEL] <= output_level_select;
                        prdata[`BIT_TRIG_EDGE] <= tcfg.pin_trigger_edge_select;
                        prdata[`BIT_TRIG_EN] <= tcfg.pin_trigger_enable;
                    end
                    `OFS_MODE: begin
                        prdata[`BIT_WAIT_MODE] <= wait_mode;
                        prdata[`FLD_SRC_HI:`FLD_SRC_LO] <= src_sel;
                    end
                    `OFS_PRESCALER: prdata[7:0] <= pre_cnt;
                    `OFS_SECONDARY: prdata[7:0] <= sec_rl;
                    `OFS_PRIMARY: prdata[7:0] <= cnt;
                    `OFS_PIN_CONFIG: begin
                        prdata[`BIT_PIN_BOTH] <= pcfg.pin_both_edge_select;
                        prdata[`BIT_PIN_IN_EN] <= pcfg.pin_input_enable;
                        prdata[`BIT_PIN_FILT_HI:`BIT_PIN_FILT_LO] <= pcfg.filter_sel;
                        prdata[`BIT_PIN_POL] <= pcfg.pin_interrupt_polarity;
                        prdata[`BIT_PIN_IRQ] <= interrupt_request_flag;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_level_select <= 1'b0;
            tcfg <= '0;
            wait_mode <= 1'b0;
            src_sel <= `SRC_DIV1;
            pcfg <= '0;
        end else if (wr) begin
            if (wr_at(paddr, `OFS_TIMER_IO_CONTROL)) begin
                output_level_select <= pwdata[`BIT_LEVEL_SEL];
                tcfg.pin_trigger_edge_select <= pwdata[`BIT_TRIG_EDGE];
                tcfg.pin_trigger_enable <= pwdata[`BIT_TRIG_EN];
            end
            if (wr_at(paddr, `OFS_MODE)) begin
                wait_mode <= pwdata[`BIT_WAIT_MODE];
                src_sel <= pwdata[`FLD_SRC_HI:`FLD_SRC_LO];
            end
            if (wr_at(paddr, `OFS_PIN_CONFIG)) begin
                pcfg.pin_both_edge_select <= pwdata[`BIT_PIN_BOTH];
                pcfg.pin_input_enable <= pwdata[`BIT_PIN_IN_EN];
                pcfg.filter_sel <= pwdata[`BIT_PIN_FILT_HI:`BIT_PIN_FILT_LO];
                pcfg.pin_interrupt_polarity <= pwdata[`BIT_PIN_POL];
            end
        end
    end

    // Pin interrupt flag is sticky; a new edge beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_request_flag <= 1'b0;
        end else if (pin_irq) begin
            interrupt_request_flag <= 1'b1;
        end else if (wr && wr_at(paddr, `OFS_PIN_CONFIG) && !pwdata[`BIT_PIN_IRQ]) begin
            interrupt_request_flag <= 1'b0;
        end
    end

    // Reload registers always take the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_rl <= `RST_BYTE;
            sec_rl <= `RST_BYTE;
            pri_rl <= `RST_BYTE;
        end else begin
            if (wr_pre) begin
                pre_rl <= pwdata[7:0];
            end
            if (wr && wr_at(paddr, `OFS_SECONDARY)) begin
                sec_rl <= pwdata[7:0];
            end
            if (wr_pri) begin
                pri_rl <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Start/stop handshake
    // ----------------------------------------
    // Two count-source edges of staging give the 1 to 2 cycle delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_start_bit <= 1'b0;
            start_stage <= 1'b0;
            count_status_flag <= 1'b0;
        end else if (force_stop) begin
            count_start_bit <= 1'b0;
            start_stage <= 1'b0;
            count_status_flag <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                count_start_bit <= pwdata[`BIT_COUNT_START];
            end
            if (tick) begin
                start_stage <= count_start_bit;
                count_status_flag <= start_stage;
            end
        end
    end

    assign trig_accept = (pin_trig | (wr_os & pwdata[`BIT_OS_START])) &
                         count_status_flag & ~oneshot_active_flag;
    assign stop_now = tick & ((os_stop_stage & oneshot_active_flag) |
                      (count_status_flag & ~start_stage));

    // If start and stop are both staged, stop wins; software must avoid it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_start_pend <= 1'b0;
            os_stop_pend <= 1'b0;
            os_start_stage <= 1'b0;
            os_stop_stage <= 1'b0;
        end else if (force_stop) begin
            os_start_pend <= 1'b0;
            os_stop_pend <= 1'b0;
            os_start_stage <= 1'b0;
            os_stop_stage <= 1'b0;
        end else begin
            if (trig_accept) begin
                os_start_pend <= 1'b1;
            end else if (tick) begin
                os_start_pend <= 1'b0;
            end
            if (wr_os && pwdata[`BIT_OS_STOP]) begin
                os_stop_pend <= 1'b1;
            end else if (tick) begin
                os_stop_pend <= 1'b0;
            end
            if (tick) begin
                os_start_stage <= os_start_pend;
                os_stop_stage <= os_stop_pend;
            end
        end
    end

    // ----------------------------------------
    // Counting engine
    // ----------------------------------------
    // A forced stop in the finishing cycle must not leave a stray request behind
    assign fin = tick & oneshot_active_flag & (state == ST_PULSE) & (pre_cnt == 8'h00) &
                 (cnt == 8'h00) & ~stop_now & ~force_stop;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            oneshot_active_flag <= 1'b0;
            pre_cnt <= `RST_BYTE;
            cnt <= `RST_BYTE;
            fin_q <= 1'b0;
        end else begin
            fin_q <= fin;
            if (force_stop || stop_now) begin
                state <= ST_IDLE;
                oneshot_active_flag <= 1'b0;
                pre_cnt <= pre_rl;
                cnt <= pri_rl;
            end else if (!count_status_flag) begin
                if (wr_pre) begin
                    pre_cnt <= pwdata[7:0];
                end
                if (wr_pri) begin
                    cnt <= pwdata[7:0];
                end
            end else if (tick && os_start_stage && !os_stop_stage && !oneshot_active_flag) begin
                oneshot_active_flag <= 1'b1;
                state <= wait_mode ? ST_WAIT : ST_PULSE;
                pre_cnt <= pre_rl;
                cnt <= pri_rl;
            end else if (tick && oneshot_active_flag) begin
                if (pre_cnt != 8'h00) begin
                    pre_cnt <= pre_cnt - 8'h01;
                end else begin
                    pre_cnt <= pre_rl;
                    if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else if (state == ST_WAIT) begin
                        cnt <= sec_rl;
                        state <= ST_PULSE;
                    end else begin
                        cnt <= pri_rl;
                        state <= ST_IDLE;
                        oneshot_active_flag <= 1'b0;
                    end
                end
            end
        end
    end

    // Pin and request share one register stage so they change together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_output_pin <= 1'b0;
            timer_request <= 1'b0;
        end else begin
            pulse_output_pin <= (state == ST_PULSE) ? ~output_level_select : output_level_select;
            timer_request <= fin_q;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence seq_underflow;
        tick && oneshot_active_flag && pre_cnt == 8'h00 && cnt == 8'h00 && !stop_now && !force_stop;
    endsequence

    chk_trigger_needs_status: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(os_start_pend) |-> $past(count_status_flag))
        else $error("trigger accepted while count stopped");
    chk_no_retrigger: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(os_start_pend) |-> !$past(oneshot_active_flag))
        else $error("trigger accepted while active");
    chk_wait_to_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (seq_underflow and state == ST_WAIT) |=> state == ST_PULSE && cnt == $past(sec_rl))
        else $error("wait underflow did not load secondary");
    chk_finish_clears: assert property (@(posedge pclk) disable iff (!presetn)
        fin |=> !oneshot_active_flag && cnt == $past(pri_rl) ##1 timer_request)
        else $error("finish did not clear active or raise request");
    chk_req_with_edge: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(timer_request) |-> pulse_output_pin != $past(pulse_output_pin))
        else $error("request not aligned with pulse end");
    chk_pin_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
        state != ST_PULSE |=> pulse_output_pin == $past(output_level_select))
        else $error("pulse pin not idle outside pulse");
    chk_force_halt: assert property (@(posedge pclk) disable iff (!presetn)
        force_stop |=> !count_status_flag && !oneshot_active_flag && state == ST_IDLE)
        else $error("forced stop did not halt");
    chk_stop_reloads: assert property (@(posedge pclk) disable iff (!presetn)
        stop_now && !force_stop |=> cnt == $past(pri_rl) && pre_cnt == $past(pre_rl))
        else $error("stop did not reload counter");
    chk_status_follows: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(count_status_flag) |-> $past(start_stage) && $past(tick))
        else $error("status rose without staged start");
    chk_run_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        count_status_flag && wr_pri && !oneshot_active_flag && !os_start_stage && !stop_now && !force_stop
        |=> cnt == $past(cnt))
        else $error("running write changed counter");
endmodule

// >>> trig_source.sv
// Far-side model of the external trigger pin: pulled high when idle.
// Assumes fire is a one-cycle request on pclk; each request gives one low pulse.
`timescale 1ns/1ps
module trig_source (
    input wire logic pclk,
    input wire logic fire,
    output logic pin
);
    logic [2:0] low_cnt = 3'h0;
    always @(posedge pclk) begin
        if (fire) begin
            low_cnt <= 3'h6;
        end else if (low_cnt != 3'h0) begin
            low_cnt <= low_cnt - 3'h1;
        end
    end
    // Low pulse outlasts the synchroniser, so one falling edge per request
    assign pin = (low_cnt == 3'h0);
endmodule

// >>> tb_top.sv
// Self-checking bench for the wait one-shot timer, driven over APB.
// Assumes zero-wait APB slave and a pulled-up trigger pin.
`timescale 1ns/1ps
`include "timer_params.svh"
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, pin, pulse, req;
    logic nb_uf = 1'b0;
    logic fire = 1'b0;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    int req_cnt = 0;
    wait_oneshot_timer i_wait_oneshot_timer(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .external_trigger_pin(pin), .neighbour_underflow(nb_uf),
        .pulse_output_pin(pulse), .timer_request(req));
    trig_source i_trig_source(.pclk, .fire, .pin);
    always #20 pclk = ~pclk;
    // Neighbour underflow every fourth cycle; run ceiling well above test length
    always @(posedge pclk) begin
        cyc++;
        nb_uf <= (cyc % 4 == 0);
        if (req === 1'b1) req_cnt++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        for (int k = 0; k < 50; k++) begin
            apb(1'b0, a, 8'h00);
            if (rd[b] === v) break;
        end
        cmp("polled flag", {31'h0, v}, {31'h0, rd[b]});
    endtask
    task automatic cfg(input logic [7:0] md, input logic [7:0] n, input logic [7:0] p, input logic [7:0] m);
        apb(1'b1, `OFS_MODE, md);
        apb(1'b1, `OFS_PRESCALER, n);
        apb(1'b1, `OFS_SECONDARY, p);
        apb(1'b1, `OFS_PRIMARY, m);
    endtask
    // Pulse width in pclk cycles; the request must mark the return to idle
    task automatic measure(input logic idle, input int w);
        int n;
        n = 0;
        for (int k = 0; k < 400 && pulse === idle; k++) @(posedge pclk);
        while (pulse === ~idle && n < 300) begin
            @(posedge pclk);
            n++;
        end
        cmp("pulse width", w, n);
        cmp("timer_request", 1, {31'h0, req});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sources;
        int wd[4] = '{2, 4, 16, 8};
        apb(1'b1, `OFS_TIMER_CONTROL, 8'h01);
        poll(`OFS_TIMER_CONTROL, `BIT_COUNT_STATUS, 1'b1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_TIMER_IO_CONTROL, {7'h0, i[0]});
            cfg({2'h0, 2'(i), 4'h0}, 8'h00, 8'h00, 8'h01);
            apb(1'b1, `OFS_ONESHOT_CONTROL, 8'h01);
            measure(i[0], wd[i]);
        end
    endtask
    task automatic t_wait;
        int r0;
        apb(1'b1, `OFS_PIN_CONFIG, 8'h02);
        apb(1'b1, `OFS_TIMER_IO_CONTROL, 8'h04);
        cfg(8'h01, 8'h01, 8'h02, 8'h1D);
        r0 = req_cnt;
        apb(1'b1, `OFS_ONESHOT_CONTROL, 8'h01);
        poll(`OFS_ONESHOT_CONTROL, `BIT_OS_ACTIVE, 1'b1);
        apb(1'b1, `OFS_ONESHOT_CONTROL, 8'h01);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        cmp("pin in wait", 0, {31'h0, pulse});
        measure(1'b0, 6);
        repeat (80) @(posedge pclk);
        cmp("request count", 1, req_cnt - r0);
        apb(1'b0, `OFS_PIN_CONFIG, 8'h00);
        cmp("pin request flag", 1, {31'h0, rd[`BIT_PIN_IRQ]});
        // Falling pin edge while idle must start a fresh wait and pulse
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        measure(1'b0, 6);
    endtask
    task automatic t_stop;
        cfg(8'h01, 8'h00, 8'h00, 8'h40);
        apb(1'b1, `OFS_ONESHOT_CONTROL, 8'h01);
        poll(`OFS_ONESHOT_CONTROL, `BIT_OS_ACTIVE, 1'b1);
        apb(1'b1, `OFS_PRIMARY, 8'h20);
        apb(1'b1, `OFS_ONESHOT_CONTROL, 8'h02);
        poll(`OFS_ONESHOT_CONTROL, `BIT_OS_ACTIVE, 1'b0);
        apb(1'b0, `OFS_PRIMARY, 8'h00);
        cmp("count after stop", 32'h20, rd);
        apb(1'b1, `OFS_TIMER_CONTROL, 8'h05);
        apb(1'b0, `OFS_TIMER_CONTROL, 8'h00);
        cmp("control after forced stop", 0, rd);
    endtask
    task automatic conclude;
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        cmp("pin in reset", 0, {31'h0, pulse});
        presetn <= 1'b1;
        apb(1'b0, `OFS_TIMER_CONTROL, 8'h00);
        cmp("control at reset", 0, rd);
        apb(1'b0, `OFS_PRESCALER, 8'h00);
        cmp("prescaler at reset", 32'hFF, rd);
        apb(1'b0, 8'h20, 8'h00);
        cmp("unmapped error", 1, {31'h0, err});
        t_sources();
        t_wait();
        t_stop();
        conclude();
    end
endmodule
